// ===== common/marr_cfg.svh
// Offsets, field positions, reset values and timing counts of the accumulate and readout block
`ifndef MARR_CFG_SVH
`define MARR_CFG_SVH

// Register byte offsets on the AXI4-Lite slave
`define MARR_OFS_MODE       8'h00
`define MARR_OFS_OPND_A     8'h04
`define MARR_OFS_EXEC       8'h08
`define MARR_OFS_LOAD       8'h0c
`define MARR_OFS_RESULT     8'h10
`define MARR_OFS_STATUS     8'h14
`define MARR_OFS_RESULT_REG_ZERO       8'h18
`define MARR_OFS_RESULT_REG_ONE       8'h1c
`define MARR_ADDR_BITS      8

// Mode value fields
`define MARR_MODE_W         7
`define MARR_MODE_OP_MSB    3
`define MARR_MODE_OP_LSB    0
`define MARR_MODE_SEL_MSB   6
`define MARR_MODE_SEL_LSB   4
`define MARR_SEL_MAX        3'h3
`define MARR_OP_MAX         4'ha

// Result register field positions
`define MARR_RESULT_FLG_LSB 16
`define MARR_RESULT_FLG_MSB 19
`define MARR_STATUS_OVF_BIT 0

// Reset values
`define MARR_RST_MODE       7'h00
`define MARR_RST_WORD       32'h0000_0000
`define MARR_RST_HALF       16'h0000
`define MARR_RST_FLAGS      4'h0

// AXI responses
`define MARR_RESP_OKAY      2'h0
`define MARR_RESP_SLVERR    2'h2

// An accumulate step finishes in this many clock cycles
`define MARR_STEP_CYCLES    1

`endif

// ===== common/marr_pkg.sv
// Types shared by the accumulate and readout block
package marr_pkg;

    typedef enum logic [3:0] {
        MARR_OP_CLEAR    = 4'h0,
        MARR_OP_LOAD16   = 4'h1,
        MARR_OP_LOAD32   = 4'h2,
        MARR_OP_READ     = 4'h3,
        MARR_OP_MAC_U    = 4'h6,
        MARR_OP_MAC_S    = 4'h7,
        MARR_OP_LOAD_R1  = 4'ha
    } marr_op_t;

    typedef struct packed {
        logic c;
        logic v;
        logic z;
        logic n;
    } marr_flags_t;

    typedef struct packed {
        marr_flags_t flags;
        logic [15:0] data;
    } marr_result_t;

    typedef struct packed {
        logic        ovf;
        logic [31:0] sum;
    } marr_step_t;

    typedef enum logic [1:0] {
        MARR_WS_IDLE    = 2'b00,
        MARR_WS_HAVE_AW = 2'b01,
        MARR_WS_RESP    = 2'b11,
        MARR_WS_HAVE_W  = 2'b10
    } marr_wstate_t;

endpackage

// ===== rtl/marr_top.sv
// Multiply-accumulate datapath with result readout behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "marr_cfg.svh"

// What this block does
// - Accumulate multiplies two 16-bit operands, adds product to result register zero.
// - Writing mode 0x00 clears both result registers at once.
// - Mode 0x01 load puts second operand low, zeroes upper half of register zero.
// - Mode 0x02 load puts first operand high, second operand low of register zero.
// - Mode 0x06 unsigned, 0x07 signed; each execute does one step, returns low half.
// - Modes 0x16 and 0x17 do the same step but return the high half.
// - Step returns flags 0b0100 on overflow, otherwise 0b0000.
// - Only signed accumulation can report overflow.
// - Signed overflow: product and accumulator share sign, sum has the other sign.
// - While overflow stands, a further overflowing step leaves the accumulated result unchanged.
// - Overflow clears on a clean step or any other execute or load outside result read mode.
// - Read modes 0x03, 0x13, 0x23, 0x33 return halves of registers zero and one.
// - Read transfers change no result register and return flags 0b0000.
// - Result registers keep their value until another operation overwrites them.
// - Mode bits 6 to 4 select the output half, bits 3 to 0 the operation.
// - Each accumulate step completes in one clock cycle.
module marr_top
    import marr_pkg::*;
(
    input  wire logic        CLK,            // System clock, 125 MHz
    input  wire logic        RST,            // Asynchronous reset, active high
    input  wire logic [7:0]  S_AXI_AWADDR,   // Write address
    input  wire logic [2:0]  S_AXI_AWPROT,   // Write protection, unused
    input  wire logic        S_AXI_AWVALID,  // Write address valid
    output logic             S_AXI_AWREADY,  // Write address ready
    input  wire logic [31:0] S_AXI_WDATA,    // Write data
    input  wire logic [3:0]  S_AXI_WSTRB,    // Write byte strobes
    input  wire logic        S_AXI_WVALID,   // Write data valid
    output logic             S_AXI_WREADY,   // Write data ready
    output logic [1:0]       S_AXI_BRESP,    // Write response
    output logic             S_AXI_BVALID,   // Write response valid
    input  wire logic        S_AXI_BREADY,   // Write response ready
    input  wire logic [7:0]  S_AXI_ARADDR,   // Read address
    input  wire logic [2:0]  S_AXI_ARPROT,   // Read protection, unused
    input  wire logic        S_AXI_ARVALID,  // Read address valid
    output logic             S_AXI_ARREADY,  // Read address ready
    output logic [31:0]      S_AXI_RDATA,    // Read data
    output logic [1:0]       S_AXI_RRESP,    // Read response
    output logic             S_AXI_RVALID,   // Read data valid
    input  wire logic        S_AXI_RREADY    // Read data ready
);

    // Offsets are word aligned; the low two address bits are ignored
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
        addr_is = (a[7:2] == ofs[7:2]);
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = addr_is(a, `MARR_OFS_MODE)   || addr_is(a, `MARR_OFS_OPND_A) ||
                      addr_is(a, `MARR_OFS_EXEC)   || addr_is(a, `MARR_OFS_LOAD)   ||
                      addr_is(a, `MARR_OFS_RESULT) || addr_is(a, `MARR_OFS_STATUS) ||
                      addr_is(a, `MARR_OFS_RESULT_REG_ZERO)   || addr_is(a, `MARR_OFS_RESULT_REG_ONE);
    endfunction

    // Output selections above 3 and operation codes above 0xa are refused
    function automatic logic mode_valid(input logic [6:0] m);
        logic [2:0] sel;
        logic [3:0] op;
        sel = m[`MARR_MODE_SEL_MSB:`MARR_MODE_SEL_LSB];
        op  = m[`MARR_MODE_OP_MSB:`MARR_MODE_OP_LSB];
        mode_valid = (sel <= `MARR_SEL_MAX) && (op <= `MARR_OP_MAX);
    endfunction

    // One accumulate step, all in one cycle
    function automatic marr_step_t mac_step(input logic [15:0] a, input logic [15:0] b,
                                            input logic [31:0] acc, input logic sgn);
        logic [31:0] prod;
        marr_step_t  r;
        if (sgn) begin
            prod = $signed({{16{a[15]}}, a}) * $signed({{16{b[15]}}, b});
        end else begin
            prod = 32'(a) * 32'(b);
        end
        r.sum = prod + acc;
        r.ovf = sgn && (prod[31] == acc[31]) && (r.sum[31] != acc[31]);
        mac_step = r;
    endfunction

    function automatic logic [15:0] pick_half(input logic [2:0] sel, input logic [31:0] r0,
                                              input logic [31:0] r1);
        case (sel)
            3'h0:    pick_half = r0[15:0];
            3'h1:    pick_half = r0[31:16];
            3'h2:    pick_half = r1[15:0];
            3'h3:    pick_half = r1[31:16];
            default: pick_half = `MARR_RST_HALF;
        endcase
    endfunction

    marr_wstate_t  wstate_q;
    logic [7:0]    awaddr_q;
    logic [31:0]   wdata_q;
    logic [3:0]    wstrb_q;
    logic          bvalid_q;
    logic [1:0]    bresp_q;
    logic          rvalid_q;
    logic [31:0]   rdata_q;
    logic [1:0]    rresp_q;

    logic [6:0]    mode_q;
    logic [15:0]   opnd_a_q;
    logic [31:0]   result_reg_zero_q;
    logic [31:0]   result_reg_one_q;
    logic          ovf_q;
    marr_result_t  result_q;

    logic          aw_take;
    logic          w_take;
    logic          do_write;
    logic [7:0]    wr_addr;
    logic [31:0]   wr_data;
    logic [3:0]    wr_strb;
    logic          ar_take;

    logic          wr_mode;
    logic          wr_opnd;
    logic          wr_exec;
    logic          wr_load;
    logic [3:0]    op;
    logic [2:0]    sel;
    logic          is_mac;
    logic          is_read;
    marr_step_t    step;
    logic          acc_hold;
    logic [31:0]   result_reg_zero_after;

    // Write channels: address and data may come in either order
    assign S_AXI_AWREADY = (wstate_q == MARR_WS_IDLE) || (wstate_q == MARR_WS_HAVE_W);
    assign S_AXI_WREADY  = (wstate_q == MARR_WS_IDLE) || (wstate_q == MARR_WS_HAVE_AW);
    assign aw_take       = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_take        = S_AXI_WVALID && S_AXI_WREADY;

    always_comb begin
        do_write = 1'b0;
        case (wstate_q)
            MARR_WS_IDLE:    do_write = aw_take && w_take;
            MARR_WS_HAVE_AW: do_write = w_take;
            MARR_WS_HAVE_W:  do_write = aw_take;
            MARR_WS_RESP:    do_write = 1'b0;
            default:         do_write = 1'b0;
        endcase
    end

    assign wr_addr = (wstate_q == MARR_WS_HAVE_AW) ? awaddr_q : S_AXI_AWADDR;
    assign wr_data = (wstate_q == MARR_WS_HAVE_W) ? wdata_q : S_AXI_WDATA;
    assign wr_strb = (wstate_q == MARR_WS_HAVE_W) ? wstrb_q : S_AXI_WSTRB;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wstate_q <= MARR_WS_IDLE;
        end else begin
            case (wstate_q)
                MARR_WS_IDLE: begin
                    if (do_write) begin
                        wstate_q <= MARR_WS_RESP;
                    end else if (aw_take) begin
                        wstate_q <= MARR_WS_HAVE_AW;
                    end else if (w_take) begin
                        wstate_q <= MARR_WS_HAVE_W;
                    end
                end
                MARR_WS_HAVE_AW: begin
                    if (do_write) begin
                        wstate_q <= MARR_WS_RESP;
                    end
                end
                MARR_WS_HAVE_W: begin
                    if (do_write) begin
                        wstate_q <= MARR_WS_RESP;
                    end
                end
                MARR_WS_RESP: begin
                    if (S_AXI_BREADY) begin
                        wstate_q <= MARR_WS_IDLE;
                    end
                end
                default: wstate_q <= MARR_WS_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            awaddr_q <= 8'h00;
            wdata_q  <= `MARR_RST_WORD;
            wstrb_q  <= 4'h0;
        end else begin
            if (aw_take) begin
                awaddr_q <= S_AXI_AWADDR;
            end
            if (w_take) begin
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `MARR_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= addr_mapped(wr_addr) ? `MARR_RESP_OKAY : `MARR_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP  = bresp_q;

    // Register write decode; mode, execute and load transfers fire only when the low byte lane is enabled
    assign wr_mode = do_write && addr_is(wr_addr, `MARR_OFS_MODE) && wr_strb[0];
    assign wr_opnd = do_write && addr_is(wr_addr, `MARR_OFS_OPND_A);
    assign wr_exec = do_write && addr_is(wr_addr, `MARR_OFS_EXEC) && wr_strb[0];
    assign wr_load = do_write && addr_is(wr_addr, `MARR_OFS_LOAD) && wr_strb[0];

    assign op      = mode_q[`MARR_MODE_OP_MSB:`MARR_MODE_OP_LSB];
    assign sel     = mode_q[`MARR_MODE_SEL_MSB:`MARR_MODE_SEL_LSB];
    assign is_mac  = (op == MARR_OP_MAC_U) || (op == MARR_OP_MAC_S);
    assign is_read = (op == MARR_OP_READ);

    always_comb begin
        step       = mac_step(opnd_a_q, wr_data[15:0], result_reg_zero_q, op == MARR_OP_MAC_S);
        // A second overflow while the flag stands does not overwrite the held sum
        acc_hold   = ovf_q && step.ovf;
        result_reg_zero_after = acc_hold ? result_reg_zero_q : step.sum;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_q <= `MARR_RST_MODE;
        end else if (wr_mode && mode_valid(wr_data[6:0])) begin
            mode_q <= wr_data[6:0];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            opnd_a_q <= `MARR_RST_HALF;
        end else if (wr_opnd) begin
            if (wr_strb[0]) begin
                opnd_a_q[7:0] <= wr_data[7:0];
            end
            if (wr_strb[1]) begin
                opnd_a_q[15:8] <= wr_data[15:8];
            end
        end
    end

    // Result register zero keeps its value unless an operation writes it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            result_reg_zero_q <= `MARR_RST_WORD;
        end else if (wr_mode && mode_valid(wr_data[6:0]) &&
                     wr_data[`MARR_MODE_OP_MSB:`MARR_MODE_OP_LSB] == MARR_OP_CLEAR) begin
            result_reg_zero_q <= `MARR_RST_WORD;
        end else if (wr_load && op == MARR_OP_LOAD16) begin
            result_reg_zero_q <= {`MARR_RST_HALF, wr_data[15:0]};
        end else if (wr_load && op == MARR_OP_LOAD32) begin
            result_reg_zero_q <= {opnd_a_q, wr_data[15:0]};
        end else if (wr_exec && is_mac) begin
            result_reg_zero_q <= result_reg_zero_after;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            result_reg_one_q <= `MARR_RST_WORD;
        end else if (wr_mode && mode_valid(wr_data[6:0]) &&
                     wr_data[`MARR_MODE_OP_MSB:`MARR_MODE_OP_LSB] == MARR_OP_CLEAR) begin
            result_reg_one_q <= `MARR_RST_WORD;
        end else if (wr_load && op == MARR_OP_LOAD_R1) begin
            result_reg_one_q <= {opnd_a_q, wr_data[15:0]};
        end
    end

    // Overflow is set by a signed step and cleared by any other execute or load outside read mode
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ovf_q <= 1'b0;
        end else if (wr_exec && is_mac) begin
            ovf_q <= step.ovf;
        end else if ((wr_exec || wr_load) && !is_read) begin
            ovf_q <= 1'b0;
        end
    end

    // Value and flags handed back by the last execute transfer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            result_q <= '0;
        end else if (wr_exec) begin
            result_q.flags   <= '0;
            result_q.flags.v <= is_mac && step.ovf;
            if (is_mac) begin
                result_q.data <= pick_half(sel, result_reg_zero_after, result_reg_one_q);
            end else begin
                result_q.data <= pick_half(sel, result_reg_zero_q, result_reg_one_q);
            end
        end
    end

    // Read channel: one read at a time, answered the cycle after it is taken
    assign S_AXI_ARREADY = !rvalid_q;
    assign ar_take       = S_AXI_ARVALID && S_AXI_ARREADY;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rvalid_q <= 1'b0;
            rdata_q  <= `MARR_RST_WORD;
            rresp_q  <= `MARR_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rresp_q  <= addr_mapped(S_AXI_ARADDR) ? `MARR_RESP_OKAY : `MARR_RESP_SLVERR;
            rdata_q  <= `MARR_RST_WORD;
            if (addr_is(S_AXI_ARADDR, `MARR_OFS_MODE)) begin
                rdata_q[6:0] <= mode_q;
            end else if (addr_is(S_AXI_ARADDR, `MARR_OFS_OPND_A)) begin
                rdata_q[15:0] <= opnd_a_q;
            end else if (addr_is(S_AXI_ARADDR, `MARR_OFS_RESULT)) begin
                rdata_q[`MARR_RESULT_FLG_MSB:0] <= result_q;
            end else if (addr_is(S_AXI_ARADDR, `MARR_OFS_STATUS)) begin
                rdata_q[`MARR_STATUS_OVF_BIT] <= ovf_q;
            end else if (addr_is(S_AXI_ARADDR, `MARR_OFS_RESULT_REG_ZERO)) begin
                rdata_q <= result_reg_zero_q;
            end else if (addr_is(S_AXI_ARADDR, `MARR_OFS_RESULT_REG_ONE)) begin
                rdata_q <= result_reg_one_q;
            end
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA  = rdata_q;
    assign S_AXI_RRESP  = rresp_q;

endmodule

// ===== testbench/marr_asserts.sv
// Bus timing checker for the accumulate and readout block
`timescale 1ns/1ps
module marr_asserts (
    input wire logic        CLK,            // Clock
    input wire logic        RST,            // Reset, active high
    input wire logic        S_AXI_AWVALID,  // Write address valid
    input wire logic        S_AXI_AWREADY,  // Write address ready
    input wire logic        S_AXI_WVALID,   // Write data valid
    input wire logic        S_AXI_WREADY,   // Write data ready
    input wire logic [1:0]  S_AXI_BRESP,    // Write response
    input wire logic        S_AXI_BVALID,   // Write response valid
    input wire logic        S_AXI_BREADY,   // Write response ready
    input wire logic        S_AXI_ARVALID,  // Read address valid
    input wire logic        S_AXI_ARREADY,  // Read address ready
    input wire logic [31:0] S_AXI_RDATA,    // Read data
    input wire logic        S_AXI_RVALID,   // Read data valid
    input wire logic        S_AXI_RREADY    // Read data ready
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence

    // A step lands in one cycle, so the answer cannot be late
    property p_wr_answer; s_wr_taken |=> S_AXI_BVALID; endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write not answered next cycle");
    property p_rd_answer; s_rd_taken |=> S_AXI_RVALID; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
    property p_b_stands; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
    a_b_stands: assert property (p_b_stands) else $error("write response dropped early");
    property p_r_stands; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
    a_r_stands: assert property (p_r_stands) else $error("read data changed while waiting");
    property p_b_done; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
    a_b_done: assert property (p_b_done) else $error("write response repeated");
    property p_r_done; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
    a_r_done: assert property (p_r_done) else $error("read response repeated");
    property p_b_blocks; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    a_b_blocks: assert property (p_b_blocks) else $error("new write accepted during response");
    property p_r_blocks; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_r_blocks: assert property (p_r_blocks) else $error("new read accepted during response");
endmodule

bind marr_top marr_asserts marr_asserts_i (.CLK(CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// ===== testbench/marr_host.sv
// Host processor model issuing register transfers over AXI4-Lite
`timescale 1ns/1ps
module marr_host (
    input  wire logic        clk,      // Clock
    output logic [7:0]       awaddr,   // Write address
    output logic             awvalid,  // Write address valid
    input  wire logic        awready,  // Write address ready
    output logic [31:0]      wdata,    // Write data
    output logic [3:0]       wstrb,    // Write strobes
    output logic             wvalid,   // Write data valid
    input  wire logic        wready,   // Write data ready
    input  wire logic [1:0]  bresp,    // Write response
    input  wire logic        bvalid,   // Write response valid
    output logic             bready,   // Write response ready
    output logic [7:0]       araddr,   // Read address
    output logic             arvalid,  // Read address valid
    input  wire logic        arready,  // Read address ready
    input  wire logic [31:0] rdata,    // Read data
    input  wire logic [1:0]  rresp,    // Read response
    input  wire logic        rvalid,   // Read data valid
    output logic             rready    // Read data ready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // Handshakes are judged at the rising edge; ready for the answer comes one edge late,
    // so the slave has to hold its response for a cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic hs;
        hs = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!hs) begin
            @(posedge clk);
            hs = bready && bvalid;
            r = bresp;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic hs;
        hs = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        while (!hs) begin
            @(posedge clk);
            hs = rready && rvalid;
            d = rdata;
            r = rresp;
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
        end
        rready <= 1'b0;
    endtask
endmodule

// ===== testbench/marr_top_tb_top.sv
// Self-checking bench for the accumulate and readout block
`timescale 1ns/1ps
`include "marr_cfg.svh"
module marr_top_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;

    always #4 clk = ~clk;

    marr_top marr_top_i (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));
    marr_host marr_host_i (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        marr_host_i.wr(a, d, r);
    endtask

    task automatic peek(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        marr_host_i.rd(a, d, r);
        check(d, exp);
    endtask

    // One operand pair per execute transfer; the host repeats as often as its sum needs
    task automatic step(input logic [15:0] a, input logic [15:0] b, input logic [31:0] exp);
        put(`MARR_OFS_OPND_A, {16'h0000, a});
        put(`MARR_OFS_EXEC, {16'h0000, b});
        peek(`MARR_OFS_RESULT, exp);
    endtask

    task automatic t_reset_and_map();
        logic [31:0] d;
        logic [1:0] r;
        peek(`MARR_OFS_RESULT_REG_ZERO, `MARR_RST_WORD);
        peek(`MARR_OFS_RESULT_REG_ONE, `MARR_RST_WORD);
        peek(`MARR_OFS_STATUS, 32'h0000_0000);
        marr_host_i.wr(8'h20, 32'h0000_0001, r);
        check({30'h0, r}, {30'h0, `MARR_RESP_SLVERR});
        marr_host_i.rd(8'h20, d, r);
        check({d[29:0], r}, {30'h0, `MARR_RESP_SLVERR});
        $display("reset and map test done");
    endtask

    task automatic t_loads();
        put(`MARR_OFS_OPND_A, 32'h0000_abcd);
        put(`MARR_OFS_MODE, 32'h0000_0001);
        put(`MARR_OFS_LOAD, 32'h0000_1234);
        peek(`MARR_OFS_RESULT_REG_ZERO, 32'h0000_1234);
        put(`MARR_OFS_MODE, 32'h0000_0002);
        put(`MARR_OFS_LOAD, 32'h0000_5678);
        peek(`MARR_OFS_RESULT_REG_ZERO, 32'habcd_5678);
        put(`MARR_OFS_MODE, 32'h0000_000a);
        put(`MARR_OFS_LOAD, 32'h0000_9999);
        peek(`MARR_OFS_RESULT_REG_ONE, 32'habcd_9999);
        put(`MARR_OFS_MODE, 32'h0000_0000);
        peek(`MARR_OFS_RESULT_REG_ZERO, 32'h0000_0000);
        peek(`MARR_OFS_RESULT_REG_ONE, 32'h0000_0000);
        $display("load test done");
    endtask

    task automatic t_unsigned();
        put(`MARR_OFS_OPND_A, 32'h0000_ffff);
        put(`MARR_OFS_MODE, 32'h0000_0002);
        put(`MARR_OFS_LOAD, 32'h0000_ffff);
        put(`MARR_OFS_MODE, 32'h0000_0006);
        step(16'h0001, 16'h0002, 32'h0000_0001);
        put(`MARR_OFS_MODE, 32'h0000_0016);
        step(16'hffff, 16'hffff, 32'h0000_fffe);
        peek(`MARR_OFS_RESULT_REG_ZERO, 32'hfffe_0002);
        peek(`MARR_OFS_STATUS, 32'h0000_0000);
        $display("unsigned test done");
    endtask

    task automatic t_signed();
        put(`MARR_OFS_MODE, 32'h0000_0000);
        put(`MARR_OFS_MODE, 32'h0000_0007);
        step(16'hffff, 16'h0003, 32'h0000_fffd);
        put(`MARR_OFS_MODE, 32'h0000_0017);
        step(16'hffff, 16'hffff, 32'h0000_ffff);
        put(`MARR_OFS_OPND_A, 32'h0000_7fff);
        put(`MARR_OFS_MODE, 32'h0000_0002);
        put(`MARR_OFS_LOAD, 32'h0000_ffff);
        put(`MARR_OFS_MODE, 32'h0000_0007);
        step(16'h0001, 16'h0001, 32'h0004_0000);
        peek(`MARR_OFS_RESULT_REG_ZERO, 32'h8000_0000);
        step(16'hffff, 16'h0001, 32'h0004_0000);
        peek(`MARR_OFS_RESULT_REG_ZERO, 32'h8000_0000);
        // Low half came from the step, the high half is fetched in read mode
        put(`MARR_OFS_MODE, 32'h0000_0013);
        step(16'h0000, 16'h0000, 32'h0000_8000);
        peek(`MARR_OFS_STATUS, 32'h0000_0001);
        put(`MARR_OFS_MODE, 32'h0000_0007);
        step(16'h0000, 16'h0000, 32'h0000_0000);
        peek(`MARR_OFS_STATUS, 32'h0000_0000);
        $display("signed test done");
    endtask

    task automatic t_readout();
        logic [6:0] modes [4] = '{7'h03, 7'h13, 7'h23, 7'h33};
        logic [15:0] halves [4] = '{16'h2222, 16'h1111, 16'h4444, 16'h3333};
        put(`MARR_OFS_OPND_A, 32'h0000_1111);
        put(`MARR_OFS_MODE, 32'h0000_0002);
        put(`MARR_OFS_LOAD, 32'h0000_2222);
        put(`MARR_OFS_OPND_A, 32'h0000_3333);
        put(`MARR_OFS_MODE, 32'h0000_000a);
        put(`MARR_OFS_LOAD, 32'h0000_4444);
        for (int i = 0; i < 4; i++) begin
            put(`MARR_OFS_MODE, {25'h0, modes[i]});
            step(16'h5555, 16'h6666, {16'h0000, halves[i]});
        end
        put(`MARR_OFS_MODE, 32'h0000_0043);
        put(`MARR_OFS_MODE, 32'h0000_000b);
        peek(`MARR_OFS_MODE, 32'h0000_0033);
        step(16'h0000, 16'h0000, 32'h0000_3333);
        peek(`MARR_OFS_RESULT_REG_ZERO, 32'h1111_2222);
        $display("readout test done");
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset_and_map();
        t_loads();
        t_unsigned();
        t_signed();
        t_readout();
        test_done();
    end
endmodule
